//--- hdl/stc_ctrl.sv
// serializer test, clock override and power-up control registers
// Summary of operation
// R1 - top inject bit corrupts one normal frame
// R2 - count field injects exactly N self-test errors
// R3 - host sets count before enabling self-test
// R4 - receiver reads error total after self-test ends
// R5 - status bit shows external oscillator strap
// R6 - external route bit picks GPO clock or pixel
// R7 - oscillator select feeds internal oscillator when set
// R8 - system holds general output two low
// R9 - general output two waits 1.3 ms
// R10 - host sets mode override when strap unknown
// R11 - processor pin should drive power-down input
// R12 - recovery writes wait over 10 ms
// R13 - recovery writes 0x28, 0x20, 0x00 to power-down
// R14 - recovery writes local, back to back
// R15 - recovery sequence briefly restarts forward output
// R16 - software avoids reserved registers and fields
// R17 - power-down bits five and three stop PLL, clock
// R18 - power-down input low holds registers at reset
// R19 - inject bit reads one until frame sent
`timescale 1ns/1ps
module stc_ctrl import stc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = STC_DEV_ADDR_DEF
) (
  // clock, reset, enable
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // power-up pins
  input  wire logic       powerdown_input_in,
  input  wire logic       ext_osc_strap_in,
  // local control port
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // forward channel
  input  wire logic       frame_start_in,
  input  wire logic       selftest_active_in,
  input  wire logic       pll_source_override_in,
  output logic            frame_error_out,
  output logic [1:0]      pll_src_sel_out,
  output logic            pll_powerdown_out,
  output logic            secondary_clock_powerdown_out,
  output logic            fwd_restart_out
);
  logic       active;
  logic       ext_osc_strap_status;
  logic       inj_single;
  logic [6:0] selftest_error_count;
  logic       pll_internal_osc_select;
  logic       pll_external_route;
  logic       pd_pll;
  logic       pd_sec;
  logic       st_q;
  logic [6:0] burst_left;
  logic [1:0] seq_step;
  logic [3:0] restart_cnt;
  logic [7:0] ptr;
  logic [7:0] wr_data;
  logic       wr_pulse;
  logic [7:0] rd_data;
  logic       wr_inj;
  logic       wr_apd;
  logic       wr_clk;
  logic       single_fire;
  logic       burst_fire;
  logic       seq_done;

  stc_i2c_port #(.DEV_ADDR(DEV_ADDR)) u_port (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .active_in    (active),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe_out   (sda_oe_out),
    .rd_data_in   (rd_data),
    .ptr_out      (ptr),
    .wr_data_out  (wr_data),
    .wr_pulse_out (wr_pulse)
  );

  assign wr_inj = wr_pulse && ptr == STC_ADDR_INJECT;
  assign wr_apd = wr_pulse && ptr == STC_ADDR_ANALOG_PD;
  assign wr_clk = wr_pulse && ptr == STC_ADDR_PLL_CLK;
  // single injection only outside self-test
  assign single_fire = frame_start_in && inj_single &&
                       !selftest_active_in; // [R1]
  // first self-test cycle loads the count, so no frame counts there
  assign burst_fire = selftest_active_in && st_q && frame_start_in &&
                      burst_left != STC_INJ_COUNT_RST; // [R2]
  assign seq_done = wr_apd && seq_step == 2'h2 &&
                    wr_data == STC_SEQ_THIRD; // [R15]

  always_comb begin
    rd_data = STC_READ_ZERO;
    unique case (ptr)
      STC_ADDR_INJECT:
        rd_data = {inj_single, selftest_error_count}; // [R19]
      STC_ADDR_PLL_CLK: begin
        rd_data[STC_CLK_STRAP_BIT] = ext_osc_strap_status; // [R5]
        rd_data[STC_CLK_EXT_BIT]   = pll_external_route;
        rd_data[STC_CLK_OSC_BIT]   = pll_internal_osc_select;
      end
      STC_ADDR_ANALOG_PD: begin
        rd_data[STC_PD_PLL_BIT] = pd_pll;
        rd_data[STC_PD_SEC_BIT] = pd_sec;
      end
      default: rd_data = STC_READ_ZERO;
    endcase
  end

  // strap caught synchronously on the rise of the power-down input
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active               <= 1'b0;
      ext_osc_strap_status <= 1'b0;
    end else if (ce_in) begin
      active <= powerdown_input_in; // [R18]
      if (!powerdown_input_in) ext_osc_strap_status <= 1'b0;
      else if (!active) ext_osc_strap_status <= ext_osc_strap_in; // [R5]
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inj_single              <= 1'b0;
      selftest_error_count    <= STC_INJ_COUNT_RST;
      pll_internal_osc_select <= STC_OSC_SEL_RST;
      pll_external_route      <= STC_EXT_ROUTE_RST;
      pd_pll                  <= 1'b0;
      pd_sec                  <= 1'b0;
    end else if (ce_in) begin
      if (!powerdown_input_in) begin // [R18]
        inj_single              <= 1'b0;
        selftest_error_count    <= STC_INJ_COUNT_RST;
        pll_internal_osc_select <= STC_OSC_SEL_RST;
        pll_external_route      <= STC_EXT_ROUTE_RST;
        pd_pll                  <= 1'b0;
        pd_sec                  <= 1'b0;
      end else begin
        // a fresh write wins over the self-clear
        if (wr_inj) inj_single <= wr_data[STC_INJ_SINGLE_BIT];
        else if (single_fire) inj_single <= 1'b0; // [R19]
        if (wr_inj) begin
          selftest_error_count <= wr_data[STC_INJ_COUNT_W-1:0]; // [R2]
        end
        if (wr_clk) begin
          pll_internal_osc_select <= wr_data[STC_CLK_OSC_BIT];
          pll_external_route      <= wr_data[STC_CLK_EXT_BIT];
        end
        if (wr_apd) begin
          pd_pll <= wr_data[STC_PD_PLL_BIT]; // [R17]
          pd_sec <= wr_data[STC_PD_SEC_BIT];
        end
      end
    end
  end

  // burst counter; a count written mid-test is only seen next run
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q            <= 1'b0;
      burst_left      <= STC_INJ_COUNT_RST;
      frame_error_out <= 1'b0;
    end else if (ce_in) begin
      st_q <= selftest_active_in && active;
      if (selftest_active_in && !st_q) begin
        burst_left <= selftest_error_count; // [R2] [R3]
      end else if (burst_fire) begin
        burst_left <= burst_left - 7'h01; // [R2]
      end
      frame_error_out <= active && (single_fire || burst_fire); // [R1]
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pll_src_sel_out               <= STC_SRC_PIXEL;
      pll_powerdown_out             <= 1'b0;
      secondary_clock_powerdown_out <= 1'b0;
    end else if (ce_in) begin
      pll_powerdown_out             <= pd_pll; // [R17]
      secondary_clock_powerdown_out <= pd_sec; // [R17]
      if (!pll_source_override_in) begin
        pll_src_sel_out <= ext_osc_strap_status ? STC_SRC_EXT
                                                : STC_SRC_PIXEL;
      end else if (pll_internal_osc_select) begin
        pll_src_sel_out <= STC_SRC_OSC; // [R7]
      end else begin
        pll_src_sel_out <= pll_external_route ? STC_SRC_EXT
                                              : STC_SRC_PIXEL; // [R6]
      end
    end
  end

  // any other write between steps breaks the back-to-back sequence
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_step        <= 2'h0;
      restart_cnt     <= 4'h0;
      fwd_restart_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_pulse) begin
        if (wr_apd && wr_data == STC_SEQ_FIRST) seq_step <= 2'h1;
        else if (wr_apd && seq_step == 2'h1 && wr_data == STC_SEQ_SECOND)
          seq_step <= 2'h2; // [R13]
        else seq_step <= 2'h0;
      end
      if (seq_done) begin
        restart_cnt     <= STC_RESTART_CYC_W; // [R15]
        fwd_restart_out <= 1'b1;
      end else if (restart_cnt != 4'h0) begin
        restart_cnt     <= restart_cnt - 4'h1;
        fwd_restart_out <= restart_cnt != 4'h1;
      end
    end
  end

  single_inject_a : assert property ( // [R1]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && active && single_fire |=> frame_error_out)
    else $error("single injection did not corrupt frame");

  inject_selfclear_a : assert property ( // [R19]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && single_fire && !wr_inj |=> !inj_single)
    else $error("inject bit did not clear after frame");

  burst_count_a : assert property ( // [R2]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && active && burst_fire |=>
      frame_error_out && burst_left == $past(burst_left) - 7'h01)
    else $error("burst injection miscounted");

  burst_zero_a : assert property ( // [R2]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && selftest_active_in && st_q &&
      burst_left == STC_INJ_COUNT_RST |=> !frame_error_out)
    else $error("error injected with zero remaining");

  strap_capture_a : assert property ( // [R5]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && powerdown_input_in && !active |=>
      ext_osc_strap_status == $past(ext_osc_strap_in))
    else $error("strap status not captured at power-up");

  pll_route_a : assert property ( // [R6]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && pll_source_override_in && !pll_internal_osc_select |=>
      pll_src_sel_out == ($past(pll_external_route) ? STC_SRC_EXT
                                                    : STC_SRC_PIXEL))
    else $error("pll source wrong for external route");

  pll_osc_a : assert property ( // [R7]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && pll_source_override_in && pll_internal_osc_select |=>
      pll_src_sel_out == STC_SRC_OSC)
    else $error("internal oscillator not selected");

  analog_pd_a : assert property ( // [R17]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && wr_apd && powerdown_input_in |=> ##1 ce_in |->
      pll_powerdown_out == $past(wr_data[STC_PD_PLL_BIT], 2))
    else $error("pll power-down does not follow register");

  restart_pulse_a : assert property ( // [R15]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && seq_done |=> fwd_restart_out [*5])
    else $error("recovery restart pulse too short");

  powerdown_hold_a : assert property ( // [R18]
    @(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && !powerdown_input_in |=>
      !inj_single && pll_internal_osc_select && !pd_pll)
    else $error("registers not held at reset in power-down");
endmodule

//--- hdl/stc_i2c_port.sv
// local two-wire register port: pointer, write and read with auto-increment
`timescale 1ns/1ps
module stc_i2c_port import stc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = STC_DEV_ADDR_DEF
) (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       active_in,
  // two-wire pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // register side
  input  wire logic [7:0] rd_data_in,
  output logic [7:0]      ptr_out,
  output logic [7:0]      wr_data_out,
  output logic            wr_pulse_out
);
  stc_port_state_t state;
  logic [3:0]      cnt;
  logic [7:0]      shift;
  logic [7:0]      tx;
  logic            scl_q;
  logic            sda_q;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_c;
  logic            stop_c;

  // pins are already synchronous, so plain edge detect on one stage
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state        <= STC_IDLE;
      cnt          <= 4'h0;
      shift        <= 8'h00;
      tx           <= 8'h00;
      ptr_out      <= 8'h00;
      wr_data_out  <= 8'h00;
      wr_pulse_out <= 1'b0;
      sda_oe_out   <= 1'b0;
      sda_out      <= 1'b0;
    end else if (ce_in) begin
      wr_pulse_out <= 1'b0;
      sda_out      <= 1'b0;
      // step only after the byte has landed at the old pointer
      if (wr_pulse_out) ptr_out <= ptr_out + 8'h01;
      if (!active_in) begin
        state      <= STC_IDLE;
        ptr_out    <= 8'h00;
        sda_oe_out <= 1'b0;
      end else if (start_c) begin
        state      <= STC_DEV;
        cnt        <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_c) begin
        state      <= STC_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (cnt < STC_BITS_PER_BYTE) begin
          shift <= {shift[6:0], sda_in};
          cnt   <= cnt + 4'h1;
        end else begin
          cnt <= 4'h0;
          if (state == STC_RDAT) begin
            // master nack ends the read burst
            // our own address ack is no data ack, so no step there
            if (sda_in) state <= STC_IDLE;
            else if (!sda_oe_out) ptr_out <= ptr_out + 8'h01;
          end
        end
      end else if (scl_fall) begin
        if (cnt == STC_BITS_PER_BYTE) begin
          sda_oe_out <= 1'b0;
          unique case (state)
            STC_DEV: begin
              if (shift[7:1] == DEV_ADDR) begin
                sda_oe_out <= 1'b1;
                state      <= shift[0] ? STC_RDAT : STC_PTR;
              end else begin
                state <= STC_IDLE;
              end
            end
            STC_PTR: begin
              ptr_out    <= shift;
              sda_oe_out <= 1'b1;
              state      <= STC_WDAT;
            end
            STC_WDAT: begin
              wr_data_out  <= shift;
              wr_pulse_out <= 1'b1;
              sda_oe_out   <= 1'b1;
            end
            STC_IDLE, STC_RDAT: ;
          endcase
        end else if (state == STC_RDAT) begin
          if (cnt == 4'h0) begin
            tx         <= {rd_data_in[6:0], 1'b0};
            sda_oe_out <= ~rd_data_in[7];
          end else begin
            tx         <= {tx[6:0], 1'b0};
            sda_oe_out <= ~tx[7];
          end
        end else if (cnt == 4'h0) begin
          sda_oe_out <= 1'b0;
        end
      end
    end
  end
endmodule

//--- hdl/stc_pkg.sv
// constants shared by the serializer test and clock override control
package stc_pkg;
  // register offsets on the local control port
  localparam logic [7:0] STC_ADDR_ANALOG_PD  = 8'h27;
  localparam logic [7:0] STC_ADDR_INJECT     = 8'h2D;
  localparam logic [7:0] STC_ADDR_PLL_CLK    = 8'h35;
  // field positions
  localparam int STC_INJ_SINGLE_BIT  = 7;
  localparam int STC_INJ_COUNT_W     = 7;
  localparam int STC_PD_PLL_BIT      = 5;
  localparam int STC_PD_SEC_BIT      = 3;
  localparam int STC_CLK_STRAP_BIT   = 3;
  localparam int STC_CLK_EXT_BIT     = 1;
  localparam int STC_CLK_OSC_BIT     = 0;
  // reset values
  localparam logic [6:0] STC_INJ_COUNT_RST   = 7'h00;
  localparam logic       STC_OSC_SEL_RST     = 1'b1;
  localparam logic       STC_EXT_ROUTE_RST   = 1'b0;
  localparam logic [7:0] STC_READ_ZERO       = 8'h00;
  // recovery write sequence values
  localparam logic [7:0] STC_SEQ_FIRST       = 8'h28;
  localparam logic [7:0] STC_SEQ_SECOND      = 8'h20;
  localparam logic [7:0] STC_SEQ_THIRD       = 8'h00;
  // pll source encoding
  localparam logic [1:0] STC_SRC_PIXEL       = 2'h0;
  localparam logic [1:0] STC_SRC_EXT         = 2'h1;
  localparam logic [1:0] STC_SRC_OSC         = 2'h2;
  // timing
  localparam int STC_CLK_PERIOD_NS   = 100;
  localparam int STC_RESTART_NS      = 500;
  localparam int STC_RESTART_CYC     =
    (STC_RESTART_NS + STC_CLK_PERIOD_NS - 1) / STC_CLK_PERIOD_NS;
  localparam logic [3:0] STC_RESTART_CYC_W = 4'(STC_RESTART_CYC);
  // control port
  localparam logic [6:0] STC_DEV_ADDR_DEF    = 7'h5A;
  localparam logic [3:0] STC_BITS_PER_BYTE   = 4'h8;
  typedef enum logic [2:0] {
    STC_IDLE, STC_DEV, STC_PTR, STC_WDAT, STC_RDAT
  } stc_port_state_t;
endpackage

//--- tb/stc_host_model.sv
// two-wire host model for the local control port
`timescale 1ns/1ps
module stc_host_model import stc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = STC_DEV_ADDR_DEF
) (
  // clock
  input  wire logic mclk_in,
  // two-wire pins
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic pins(input logic c, input logic l, input int n);
    scl_out = c;
    sda_low_out = l;
    tick(n);
  endtask
  // sda released before scl rises, so a repeated start is clean
  task automatic start_cond();
    pins(1'b0, sda_low_out, 1);
    pins(1'b0, 1'b0, 2);
    pins(1'b1, 1'b0, 3);
    pins(1'b1, 1'b1, 3);
  endtask
  task automatic stop_cond();
    pins(1'b0, sda_low_out, 1);
    pins(1'b0, 1'b1, 2);
    pins(1'b1, 1'b1, 3);
    pins(1'b1, 1'b0, 3);
  endtask
  // sda moves one cycle after scl falls, never with it
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      pins(1'b0, sda_low_out, 1);
      pins(1'b0, !b[i], 2);
      pins(1'b1, !b[i], 3);
    end
    pins(1'b0, sda_low_out, 1);
    pins(1'b0, 1'b0, 2);
    pins(1'b1, 1'b0, 2);
    ack = !sda_in;
    tick(1);
  endtask
  // single-byte reads only: always ends with a nack
  task automatic recv_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      pins(1'b0, 1'b0, 3);
      pins(1'b1, 1'b0, 2);
      d[i] = sda_in;
      tick(1);
    end
    pins(1'b0, 1'b0, 3);
    pins(1'b1, 1'b0, 3);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p,
                           input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(p, a1);
    send_byte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic a;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, a);
    send_byte(p, a);
    start_cond();
    send_byte({DEV_ADDR, 1'b1}, a);
    recv_byte(d);
    stop_cond();
  endtask
endmodule

//--- tb/test_stc_ctrl.sv
// register-level test of the serializer test and clock override control
`timescale 1ns/1ps
module test_stc_ctrl import stc_pkg::*;;
  logic       mclk_in, rst_n_in, ce_in, pd, strap, scl, sda_low, sda_line;
  logic       frame_start, selftest, override, sda_o, sda_oe, ferr;
  logic       pll_pd, sec_pd, restart, ok;
  logic [1:0] sel;
  int         num_errors = 0, tests_run = 0, cyc = 0, n_ferr = 0;
  int         n_rst = 0, e = 0;
  int         cnt [4] = '{0, 1, 3, 127};
  // open-drain line with pull-up
  assign sda_line = (sda_low || sda_oe) ? 1'b0 : 1'b1;
  stc_ctrl i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .powerdown_input_in(pd), .ext_osc_strap_in(strap),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .frame_start_in(frame_start),
    .selftest_active_in(selftest), .pll_source_override_in(override),
    .frame_error_out(ferr), .pll_src_sel_out(sel),
    .pll_powerdown_out(pll_pd), .secondary_clock_powerdown_out(sec_pd),
    .fwd_restart_out(restart)
  );
  stc_host_model i_host (
    .mclk_in(mclk_in), .sda_in(sda_line), .scl_out(scl),
    .sda_low_out(sda_low)
  );
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic finish_test();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // pulse and cycle counters; ceiling well above the expected run
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (ferr === 1'b1) n_ferr <= n_ferr + 1;
    if (restart === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read_reg(p, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.write_reg(STC_DEV_ADDR_DEF, p, d, ok);
    chk(8'(ok), 8'h01);
  endtask
  task automatic frame();
    frame_start = 1'b1;
    i_host.tick(1);
    frame_start = 1'b0;
    i_host.tick(3);
  endtask
  // strap is only caught as the power-down input rises
  task automatic power_cycle(input logic s);
    pd = 1'b0;
    i_host.tick(3);
    // strap changes in the same step as the power-down input rises and then stays
    strap = s;
    pd = 1'b1;
    i_host.tick(4);
  endtask
  task automatic sel_is(input logic [1:0] exp);
    i_host.tick(3);
    chk(8'(sel), 8'(exp));
  endtask
  initial begin
    {rst_n_in, pd, strap, frame_start, selftest, override} = 6'h00;
    ce_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    rst_n_in = 1'b1;
    power_cycle(1'b0);
    rd(STC_ADDR_INJECT, 8'h00);
    rd(STC_ADDR_PLL_CLK, 8'h01);
    rd(STC_ADDR_ANALOG_PD, 8'h00);
    wr(8'h2E, 8'h55);
    rd(8'h2E, 8'h00);
    sel_is(STC_SRC_PIXEL);
    override = 1'b1;
    sel_is(STC_SRC_OSC);
    wr(STC_ADDR_PLL_CLK, 8'h02);
    sel_is(STC_SRC_EXT);
    wr(STC_ADDR_PLL_CLK, 8'h00);
    sel_is(STC_SRC_PIXEL);
    wr(STC_ADDR_PLL_CLK, 8'hFF);
    rd(STC_ADDR_PLL_CLK, 8'h03);
    sel_is(STC_SRC_OSC);
    power_cycle(1'b1);
    rd(STC_ADDR_PLL_CLK, 8'h09);
    override = 1'b0;
    sel_is(STC_SRC_EXT);
    power_cycle(1'b0);
    rd(STC_ADDR_PLL_CLK, 8'h01);
    // single error: one frame corrupted, then the bit self-clears
    wr(STC_ADDR_INJECT, 8'h80);
    rd(STC_ADDR_INJECT, 8'h80);
    e = n_ferr;
    frame();
    frame();
    chk(8'(n_ferr - e), 8'h01);
    rd(STC_ADDR_INJECT, 8'h00);
    // clock enable low freezes a pending single error
    wr(STC_ADDR_INJECT, 8'h80);
    e = n_ferr;
    ce_in = 1'b0;
    frame();
    ce_in = 1'b1;
    chk(8'(n_ferr - e), 8'h00);
    rd(STC_ADDR_INJECT, 8'h80);
    frame();
    chk(8'(n_ferr - e), 8'h01);
    rd(STC_ADDR_INJECT, 8'h00);
    // self-test counts, zero and full field included
    for (int i = 0; i < 4; i++) begin
      wr(STC_ADDR_INJECT, 8'(cnt[i]));
      selftest = 1'b1;
      i_host.tick(3);
      e = n_ferr;
      repeat (cnt[i] + 2) frame();
      selftest = 1'b0;
      i_host.tick(2);
      chk(8'(n_ferr - e), 8'(cnt[i]));
    end
    // interrupted sequence gives no restart
    e = n_rst;
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_FIRST);
    chk(8'({pll_pd, sec_pd}), 8'h03);
    wr(STC_ADDR_INJECT, 8'h00);
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_SECOND);
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_THIRD);
    i_host.tick(10);
    chk(8'(n_rst - e), 8'h00);
    // host wait before recovery is shortened; the block keeps no timer
    // for it, so a long idle would only cost run time
    // full recovery sequence, writes back to back on the local port
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_FIRST);
    rd(STC_ADDR_ANALOG_PD, 8'h28);
    e = n_rst;
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_FIRST);
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_SECOND);
    chk(8'({pll_pd, sec_pd}), 8'h02);
    wr(STC_ADDR_ANALOG_PD, STC_SEQ_THIRD);
    i_host.tick(10);
    chk(8'(n_rst - e), 8'(STC_RESTART_CYC));
    chk(8'({pll_pd, sec_pd}), 8'h00);
    // foreign device address is ignored
    i_host.write_reg(7'h11, STC_ADDR_INJECT, 8'h05, ok);
    chk(8'(ok), 8'h00);
    rd(STC_ADDR_INJECT, 8'h00);
    chk(8'(sda_o), 8'h00);
    finish_test();
  end
endmodule
